// file: core/bcs_pkg.sv
package bcs_pkg;
    // register offsets
    localparam logic [7:0] ADDR_BAUD_LO = 8'h00;
    localparam logic [7:0] ADDR_BAUD_HI = 8'h01;
    localparam logic [7:0] ADDR_CFG_LO = 8'h02;
    localparam logic [7:0] ADDR_CFG_HI = 8'h03;
    localparam logic [7:0] ADDR_PIN_LEVEL = 8'h04;
    localparam logic [7:0] ADDR_RESERVED = 8'h05;
    localparam logic [7:0] ADDR_OWN_ADDR = 8'h06;
    localparam logic [7:0] ADDR_SCL_LOW = 8'h07;
    localparam logic [7:0] ADDR_SCL_HIGH = 8'h08;
    localparam logic [7:0] ADDR_TIMEOUT = 8'h09;
    localparam logic [7:0] ADDR_RESULT = 8'h0a;
    // reset values
    localparam logic [7:0] RST_BAUD_LO = 8'hf0;
    localparam logic [7:0] RST_BAUD_HI = 8'h02;
    localparam logic [7:0] RST_CFG = 8'h55;
    localparam logic [7:0] RST_PIN_LATCH = 8'hff;
    localparam logic [7:0] RST_OWN_ADDR = 8'h26;
    localparam logic [7:0] RST_SCL_LOW = 8'h13;
    localparam logic [7:0] RST_SCL_HIGH = 8'h13;
    localparam logic [7:0] RST_TIMEOUT = 8'h66;
    localparam logic [7:0] RST_RESULT = 8'hf0;
    // field positions of the time-out register
    localparam int TO_ENABLE_BIT = 0;
    localparam int TO_FIELD_LSB = 1;
    // pin drive codes
    localparam logic [1:0] MODE_QUASI = 2'h0;
    localparam logic [1:0] MODE_INPUT = 2'h1;
    localparam logic [1:0] MODE_PUSH = 2'h2;
    localparam logic [1:0] MODE_OPEN = 2'h3;
    // result codes, upper nibble always ones
    localparam logic [3:0] RESULT_UPPER = 4'hf;
    localparam logic [3:0] RES_OK = 4'h0;
    localparam logic [3:0] RES_ADDR_REFUSED = 4'h1;
    localparam logic [3:0] RES_DATA_REFUSED = 4'h2;
    localparam logic [3:0] RES_TIMEOUT = 4'h8;
    // timing
    localparam int CLK_FREQ_HZ = 100000000;
    localparam int REF_FREQ_HZ = 7372800;
    localparam int REF_ACC_W = 27;
    localparam int BAUD_BASE = 16;
    localparam int SCL_MULT = 2;
    localparam int TO_UNIT = 256;
    localparam int TO_BASE_HZ = 57600;
    localparam int TO_PRESCALE = TO_UNIT * REF_FREQ_HZ / TO_BASE_HZ;

    typedef enum logic [1:0] {
        BCS_SCL_IDLE = 2'b00,
        BCS_SCL_LOW = 2'b01,
        BCS_SCL_HIGH = 2'b11
    } bcs_scl_state_t;

    // drive code of one pin out of the joined config registers
    function automatic logic [1:0] bcs_pin_mode(input logic [15:0] cfg, input int idx);
        bcs_pin_mode = cfg[2*idx +: 2];
    endfunction
endpackage

// file: core/bcs_ref_tick.sv
`timescale 1ns/1ns
module bcs_ref_tick
    import bcs_pkg::*;
#(
    parameter int INC = REF_FREQ_HZ,
    parameter int MODULUS = CLK_FREQ_HZ
)(
    input wire logic clk,
    input wire logic resetn,
    output logic tick_r
);
    logic [REF_ACC_W-1:0] acc_r;
    logic [REF_ACC_W:0] sum;

    // fractional accumulator, one pulse per reference period on average
    assign sum = {1'b0, acc_r} + (REF_ACC_W+1)'(INC);

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            acc_r <= '0;
            tick_r <= 1'b0;
        end
        else if (sum >= (REF_ACC_W+1)'(MODULUS))
        begin
            acc_r <= REF_ACC_W'(sum - (REF_ACC_W+1)'(MODULUS));
            tick_r <= 1'b1;
        end
        else
        begin
            acc_r <= sum[REF_ACC_W-1:0];
            tick_r <= 1'b0;
        end
    end
endmodule

// file: core/bcs_tick_div.sv
`timescale 1ns/1ns
module bcs_tick_div #(
    parameter int W = 17
)(
    input wire logic clk,
    input wire logic resetn,
    input wire logic en,
    input wire logic restart,
    input wire logic [W-1:0] limit,
    output logic tick_r
);
    logic [W-1:0] cnt_r;
    logic wrap;

    // a limit of zero behaves as one
    assign wrap = (limit == '0) || (cnt_r >= limit - W'(1));

    always_ff @(posedge clk)
    begin
        if (!resetn || restart)
        begin
            cnt_r <= '0;
            tick_r <= 1'b0;
        end
        else
        begin
            tick_r <= en && wrap;
            if (en)
                cnt_r <= wrap ? '0 : cnt_r + W'(1);
        end
    end
endmodule

// file: core/bcs_regs.sv
// Function
// RULE1: uart tick is reference over sixteen-plus-divisor
// RULE2: new divisor applies on high byte write
// RULE3: two-bit drive code per pin
// RULE4: config low pins 0-3, high 4-7
// RULE5: quasi mode weak high, strong low
// RULE6: input-only pin is never driven
// RULE7: push-pull drives latch value strongly
// RULE8: open-drain pulls low only, no pull-up
// RULE9: level read shows pins, write updates outputs
// RULE10: one sets pin high, zero low
// RULE11: all pins are inputs after reset
// RULE12: own address kept, lsb unused
// RULE13: scl rate is reference over twice sum
// RULE14: high and low counts set phase lengths
// RULE15: enabled time-out resets the bus engine
// RULE16: time-out counter reloads on each step
// RULE17: enable bit plus seven-bit period field
// RULE18: result codes with upper nibble ones
// RULE19: write command applies each write at once
// RULE20: read command returns register contents
// RULE21: divisor defaults give 9600 bit/s
// RULE22: reserved slot ignores writes, reads zero
// RULE23: time-out code stays until next result
`timescale 1ns/1ns
module bcs_regs
    import bcs_pkg::*;
#(
    parameter int PINS = 8,
    parameter int TO_PRESCALE_TICKS = TO_PRESCALE
)(
    input wire logic clk,
    input wire logic resetn,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata_r,
    output logic reg_rd_valid_r,
    output logic uart_clk_tick_r,
    input wire logic [PINS-1:0] pin_in,
    output logic [PINS-1:0] pin_out_r,
    output logic [PINS-1:0] pin_oe_r,
    output logic [PINS-1:0] pin_weak_pullup_r,
    output logic [7:0] own_bus_address_r,
    input wire logic i2c_active,
    input wire logic i2c_step,
    input wire logic scl_in,
    input wire logic result_valid,
    input wire logic [3:0] result_code,
    output logic scl_out_r,
    output logic i2c_fsm_reset_r
);
    logic [7:0] baud_lo_r;
    logic [7:0] baud_hi_r;
    logic [15:0] baud_active_r;
    logic [15:0] cfg_r;
    logic [PINS-1:0] latch_r;
    logic [7:0] scl_low_r;
    logic [7:0] scl_high_r;
    logic [7:0] timeout_r;
    logic [7:0] result_r;
    logic [7:0] rdata_nxt;
    logic ref_tick;
    logic [16:0] baud_limit;
    bcs_scl_state_t scl_state_r;
    logic [8:0] scl_cnt_r;
    logic scl_low_done;
    logic scl_high_done;
    logic to_reload;
    logic pre_tick;
    logic [6:0] to_cnt_r;
    logic to_fire;

    bcs_ref_tick u_ref (
        .clk(clk),
        .resetn(resetn),
        .tick_r(ref_tick)
    );

    // register writes apply in the cycle they arrive
    // RULE19: immediate write
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            baud_lo_r <= RST_BAUD_LO;
            baud_hi_r <= RST_BAUD_HI;
            own_bus_address_r <= RST_OWN_ADDR;
            scl_low_r <= RST_SCL_LOW;
            scl_high_r <= RST_SCL_HIGH;
            timeout_r <= RST_TIMEOUT;
        end
        else if (reg_wr_en)
        begin
            case (reg_addr)
                ADDR_BAUD_LO: baud_lo_r <= reg_wdata;
                ADDR_BAUD_HI: baud_hi_r <= reg_wdata;
                // RULE12: own address kept
                ADDR_OWN_ADDR: own_bus_address_r <= reg_wdata; // lsb stored as written
                ADDR_SCL_LOW: scl_low_r <= reg_wdata;
                ADDR_SCL_HIGH: scl_high_r <= reg_wdata;
                ADDR_TIMEOUT: timeout_r <= reg_wdata;
                default: ; // reserved and read-only slots ignore writes
            endcase
        end
    end

    // divisor in use changes only with the high byte
    // RULE2: apply on high write
    always_ff @(posedge clk)
    begin
        if (!resetn)
            // RULE21: 9600 default divisor
            baud_active_r <= {RST_BAUD_HI, RST_BAUD_LO};
        else if (reg_wr_en && reg_addr == ADDR_BAUD_HI)
            baud_active_r <= {reg_wdata, baud_lo_r};
    end

    // RULE1: baud divider
    assign baud_limit = 17'(BAUD_BASE) + {1'b0, baud_active_r};

    bcs_tick_div #(
        .W(17)
    ) u_baud (
        .clk(clk),
        .resetn(resetn),
        .en(ref_tick),
        .restart(1'b0),
        .limit(baud_limit),
        .tick_r(uart_clk_tick_r)
    );

    // drive config, all pins input-only after reset
    // RULE11: reset as inputs
    always_ff @(posedge clk)
    begin
        if (!resetn)
            cfg_r <= {RST_CFG, RST_CFG};
        else if (reg_wr_en && reg_addr == ADDR_CFG_LO)
            cfg_r[7:0] <= reg_wdata;
        else if (reg_wr_en && reg_addr == ADDR_CFG_HI)
            cfg_r[15:8] <= reg_wdata;
    end

    // per-pin latch and drivers
    genvar gi;
    generate
        for (gi = 0; gi < PINS; gi++)
        begin : g_pin
            // RULE10: latch follows written bit, except on an input-only pin, which keeps its latch
            always_ff @(posedge clk)
            begin
                if (!resetn)
                    latch_r[gi] <= RST_PIN_LATCH[gi];
                else if (reg_wr_en && reg_addr == ADDR_PIN_LEVEL && bcs_pin_mode(cfg_r, gi) != MODE_INPUT)
                    latch_r[gi] <= reg_wdata[gi];
            end

            // RULE3: decode drive code
            always_ff @(posedge clk)
            begin
                if (!resetn)
                begin
                    pin_out_r[gi] <= 1'b0;
                    pin_oe_r[gi] <= 1'b0;
                    pin_weak_pullup_r[gi] <= 1'b0;
                end
                else
                begin
                    case (bcs_pin_mode(cfg_r, gi))
                        MODE_QUASI:
                        begin
                            // RULE5: weak high strong low
                            pin_out_r[gi] <= 1'b0;
                            pin_oe_r[gi] <= !latch_r[gi];
                            pin_weak_pullup_r[gi] <= latch_r[gi];
                        end
                        MODE_PUSH:
                        begin
                            // RULE7: strong both ways
                            pin_out_r[gi] <= latch_r[gi];
                            pin_oe_r[gi] <= 1'b1;
                            pin_weak_pullup_r[gi] <= 1'b0;
                        end
                        MODE_OPEN:
                        begin
                            // RULE8: pull low only
                            pin_out_r[gi] <= 1'b0;
                            pin_oe_r[gi] <= !latch_r[gi];
                            pin_weak_pullup_r[gi] <= 1'b0;
                        end
                        default:
                        begin
                            // RULE6: input only
                            pin_out_r[gi] <= 1'b0;
                            pin_oe_r[gi] <= 1'b0;
                            pin_weak_pullup_r[gi] <= 1'b0;
                        end
                    endcase
                end
            end
        end
    endgenerate

    // read mux
    // RULE20: register read data
    always_comb
    begin
        case (reg_addr)
            ADDR_BAUD_LO: rdata_nxt = baud_lo_r;
            ADDR_BAUD_HI: rdata_nxt = baud_hi_r;
            // RULE4: config halves
            ADDR_CFG_LO: rdata_nxt = cfg_r[7:0];
            ADDR_CFG_HI: rdata_nxt = cfg_r[15:8];
            // RULE9: actual pin levels
            ADDR_PIN_LEVEL: rdata_nxt = 8'(pin_in);
            ADDR_OWN_ADDR: rdata_nxt = own_bus_address_r;
            ADDR_SCL_LOW: rdata_nxt = scl_low_r;
            ADDR_SCL_HIGH: rdata_nxt = scl_high_r;
            ADDR_TIMEOUT: rdata_nxt = timeout_r;
            ADDR_RESULT: rdata_nxt = result_r;
            // RULE22: reserved reads zero
            default: rdata_nxt = 8'h00;
        endcase
    end

    // answer one cycle after the read strobe
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            reg_rdata_r <= 8'h00;
            reg_rd_valid_r <= 1'b0;
        end
        else
        begin
            reg_rd_valid_r <= reg_rd_en;
            if (reg_rd_en)
                reg_rdata_r <= rdata_nxt;
        end
    end

    // each phase lasts twice its count in reference ticks
    // RULE14: phase lengths
    assign scl_low_done = ({1'b0, scl_cnt_r} + 10'd1) >= 10'(SCL_MULT * scl_low_r);
    assign scl_high_done = ({1'b0, scl_cnt_r} + 10'd1) >= 10'(SCL_MULT * scl_high_r);

    // RULE13: scl generator
    always_ff @(posedge clk)
    begin
        if (!resetn || i2c_fsm_reset_r)
        begin
            scl_state_r <= BCS_SCL_IDLE;
            scl_cnt_r <= 9'h000;
        end
        else
        begin
            case (scl_state_r)
                BCS_SCL_IDLE:
                begin
                    scl_cnt_r <= 9'h000;
                    if (i2c_active)
                        scl_state_r <= BCS_SCL_LOW;
                end
                BCS_SCL_LOW:
                begin
                    if (!i2c_active)
                        scl_state_r <= BCS_SCL_IDLE;
                    else if (ref_tick && scl_low_done)
                    begin
                        scl_state_r <= BCS_SCL_HIGH;
                        scl_cnt_r <= 9'h000;
                    end
                    else if (ref_tick)
                        scl_cnt_r <= scl_cnt_r + 9'h001;
                end
                BCS_SCL_HIGH:
                begin
                    // a slave holding scl low stretches the high phase
                    if (!i2c_active)
                        scl_state_r <= BCS_SCL_IDLE;
                    else if (ref_tick && scl_in && scl_high_done)
                    begin
                        scl_state_r <= BCS_SCL_LOW;
                        scl_cnt_r <= 9'h000;
                    end
                    else if (ref_tick && scl_in)
                        scl_cnt_r <= scl_cnt_r + 9'h001;
                end
                default:
                    scl_state_r <= BCS_SCL_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
            scl_out_r <= 1'b1;
        else
            scl_out_r <= scl_state_r != BCS_SCL_LOW;
    end

    // time-out prescaler restarts with every reload
    // RULE16: reload on step
    assign to_reload = i2c_step || !i2c_active || scl_in || i2c_fsm_reset_r;

    bcs_tick_div #(
        .W(16)
    ) u_to_pre (
        .clk(clk),
        .resetn(resetn),
        .en(ref_tick),
        .restart(to_reload),
        .limit(16'(TO_PRESCALE_TICKS)),
        .tick_r(pre_tick)
    );

    // one bit wider so a saturated count still fires
    // RULE17: enable bit and period
    assign to_fire = timeout_r[TO_ENABLE_BIT] && !to_reload && pre_tick
                     && ({1'b0, to_cnt_r} + 8'd1) >= {1'b0, timeout_r[7:TO_FIELD_LSB]};

    always_ff @(posedge clk)
    begin
        if (!resetn || to_reload)
            to_cnt_r <= 7'h00;
        else if (pre_tick && to_cnt_r != 7'h7f)
            to_cnt_r <= to_cnt_r + 7'd1;
    end

    // RULE15: reset the bus engine
    always_ff @(posedge clk)
    begin
        if (!resetn)
            i2c_fsm_reset_r <= 1'b0;
        else
            i2c_fsm_reset_r <= to_fire;
    end

    // time-out code outranks a result in the same cycle
    // RULE18: result codes
    // RULE23: time-out stays
    always_ff @(posedge clk)
    begin
        if (!resetn)
            result_r <= RST_RESULT;
        else if (to_fire)
            result_r <= {RESULT_UPPER, RES_TIMEOUT};
        else if (result_valid)
            result_r <= {RESULT_UPPER, result_code};
    end

    // checks
    baud_apply_a: // RULE2
    assert property (@(posedge clk) disable iff (!resetn)
        reg_wr_en && reg_addr == ADDR_BAUD_HI |=> baud_active_r == {$past(reg_wdata), baud_lo_r})
    else $error("divisor not applied on high byte write");

    baud_hold_a: // RULE2
    assert property (@(posedge clk) disable iff (!resetn)
        reg_wr_en && reg_addr == ADDR_BAUD_LO |=> $stable(baud_active_r))
    else $error("divisor changed on low byte write");

    quasi_drive_a: // RULE5
    assert property (@(posedge clk) disable iff (!resetn)
        cfg_r[1:0] == MODE_QUASI |=> pin_oe_r[0] == !$past(latch_r[0]) && !pin_out_r[0]
        && pin_weak_pullup_r[0] == $past(latch_r[0]))
    else $error("quasi pin drive wrong");

    input_drive_a: // RULE6
    assert property (@(posedge clk) disable iff (!resetn)
        cfg_r[1:0] == MODE_INPUT |=> !pin_oe_r[0] && !pin_weak_pullup_r[0])
    else $error("input pin driven");

    push_drive_a: // RULE7
    assert property (@(posedge clk) disable iff (!resetn)
        cfg_r[5:4] == MODE_PUSH |=> pin_oe_r[2] && pin_out_r[2] == $past(latch_r[2]))
    else $error("push-pull pin drive wrong");

    open_drive_a: // RULE8
    assert property (@(posedge clk) disable iff (!resetn)
        cfg_r[7:6] == MODE_OPEN |=> !pin_out_r[3] && !pin_weak_pullup_r[3]
        && pin_oe_r[3] == !$past(latch_r[3]))
    else $error("open-drain pin drive wrong");

    pin_read_a: // RULE9
    assert property (@(posedge clk) disable iff (!resetn)
        reg_rd_en && reg_addr == ADDR_PIN_LEVEL |=> reg_rd_valid_r && reg_rdata_r == 8'($past(pin_in)))
    else $error("pin level read wrong");

    reserved_read_a: // RULE22
    assert property (@(posedge clk) disable iff (!resetn)
        reg_rd_en && reg_addr == ADDR_RESERVED |=> reg_rd_valid_r && reg_rdata_r == 8'h00)
    else $error("reserved slot read not zero");

    result_upper_a: // RULE18
    assert property (@(posedge clk) disable iff (!resetn)
        result_r[7:4] == RESULT_UPPER)
    else $error("result upper nibble not ones");

    timeout_code_a: // RULE15
    assert property (@(posedge clk) disable iff (!resetn)
        i2c_fsm_reset_r |-> result_r == {RESULT_UPPER, RES_TIMEOUT} ##1 scl_state_r == BCS_SCL_IDLE)
    else $error("time-out without time-out code");

    timeout_sticky_a: // RULE23
    assert property (@(posedge clk) disable iff (!resetn)
        result_r == {RESULT_UPPER, RES_TIMEOUT} && !result_valid |=> result_r == {RESULT_UPPER, RES_TIMEOUT})
    else $error("time-out code lost");

    timeout_gate_a: // RULE17
    assert property (@(posedge clk) disable iff (!resetn)
        !timeout_r[TO_ENABLE_BIT] |=> !i2c_fsm_reset_r)
    else $error("time-out fired while disabled");
endmodule

// file: verification/bcs_pin_world.sv
`timescale 1ns/1ns
module bcs_pin_world (
    input wire logic [7:0] drive_val,
    input wire logic [7:0] drive_en,
    input wire logic [7:0] weak_en,
    input wire logic [7:0] ext_low,
    input wire logic scl_drive,
    input wire logic scl_hold,
    output logic [7:0] pin_in,
    output logic scl_in
);
    // board pull-ups on every pin, strong drive wins, else outside pull-down
    // wire level resolution
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (drive_en[i])
                pin_in[i] = drive_val[i];
            else
                pin_in[i] = ~ext_low[i] | (weak_en[i] & ~ext_low[i]);
        end
    end
    // open-drain clock line with pull-up, a stuck target holds it low
    assign scl_in = scl_drive & ~scl_hold;
endmodule

// file: verification/bridge_config_status_registers_bench.sv
`timescale 1ns/1ns
module bridge_config_status_registers_bench
    import bcs_pkg::*;
;
    logic clk;
    logic resetn;
    logic reg_wr_en;
    logic reg_rd_en;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] rdata;
    logic rd_valid;
    logic uart_tick;
    logic [7:0] pin_in;
    logic [7:0] pin_out;
    logic [7:0] pin_oe;
    logic [7:0] pin_weak;
    logic [7:0] own_addr;
    logic i2c_active;
    logic i2c_step;
    logic scl_in;
    logic scl_out;
    logic result_valid;
    logic [3:0] result_code;
    logic fsm_reset;
    logic [7:0] ext_low;
    logic scl_hold;
    int errors;
    int tests_run;
    int cyc;
    int fires;
    int n;
    logic [7:0] rst_vals [11] = '{8'hf0, 8'h02, 8'h55, 8'h55, 8'hff, 8'h00, 8'h26, 8'h13, 8'h13, 8'h66, 8'hf0};
    // address, write data, value read back
    logic [23:0] rows [9] = '{{8'h06, 8'h4c, 8'h4c}, {8'h07, 8'h05, 8'h05}, {8'h08, 8'h03, 8'h03},
        {8'h09, 8'h02, 8'h02}, {8'h05, 8'haa, 8'h00}, {8'h0a, 8'h00, 8'hf0}, {8'h0b, 8'h33, 8'h00},
        {8'h00, 8'h12, 8'h12}, {8'h01, 8'h00, 8'h00}};

    bcs_regs #(.PINS(8), .TO_PRESCALE_TICKS(4)) dut (.clk(clk), .resetn(resetn), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_r(rdata),
        .reg_rd_valid_r(rd_valid), .uart_clk_tick_r(uart_tick), .pin_in(pin_in), .pin_out_r(pin_out),
        .pin_oe_r(pin_oe), .pin_weak_pullup_r(pin_weak), .own_bus_address_r(own_addr),
        .i2c_active(i2c_active), .i2c_step(i2c_step), .scl_in(scl_in), .result_valid(result_valid),
        .result_code(result_code), .scl_out_r(scl_out), .i2c_fsm_reset_r(fsm_reset));

    bcs_pin_world world (.drive_val(pin_out), .drive_en(pin_oe), .weak_en(pin_weak), .ext_low(ext_low),
        .scl_drive(scl_out), .scl_hold(scl_hold), .pin_in(pin_in), .scl_in(scl_in));

    // clock, run limit and count of bus engine resets
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (fsm_reset === 1'b1)
            fires++;
        if (cyc == 80000)
        begin
            errors++;
            summarize();
        end
    end

    task automatic summarize;
        if (errors == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic chk_rng(input string name, input int lo, input int hi, input int got);
        tests_run++;
        if (got < lo || got > hi)
        begin
            errors++;
            $display("wrong value %s expected %0d..%0d seen %0d", name, lo, hi, got);
        end
    endtask
    task automatic tick1;
        @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr_en <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_rd_en <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd_en <= 1'b0;
        #1;
        chk8("read valid", 8'h01, {7'h00, rd_valid});
        chk8("read data", exp, rdata);
    endtask
    // skip to a tick, then count the cycles up to the next one
    task automatic chk_baud(input logic [15:0] div);
        int k;
        int e;
        k = 0;
        while (uart_tick !== 1'b1 && k < 12000)
        begin
            tick1();
            k++;
        end
        k = 0;
        do
        begin
            tick1();
            k++;
        end while (uart_tick !== 1'b1 && k < 12000);
        e = int'((64'd16 + div) * CLK_FREQ_HZ / REF_FREQ_HZ);
        chk_rng("uart tick gap", e - 2, e + 2, k);
    endtask
    // length of one whole run of the clock line at level v
    task automatic scl_run(input logic v, output int r);
        int k;
        k = 0;
        while (scl_out === v && k < 500)
        begin
            tick1();
            k++;
        end
        while (scl_out !== v && k < 1000)
        begin
            tick1();
            k++;
        end
        r = 0;
        while (scl_out === v && r < 500)
        begin
            tick1();
            r++;
        end
    endtask

    initial
    begin
        {resetn, reg_wr_en, reg_rd_en, i2c_active, i2c_step, result_valid, scl_hold} = '0;
        {reg_addr, reg_wdata, ext_low, result_code} = '0;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        tick1();
        chk8("drive enable", 8'h00, pin_oe);
        chk8("scl idle", 8'h01, {7'h00, scl_out});
        for (int a = 0; a < 11; a++)
            rd(a[7:0], rst_vals[a]);
        chk_baud(16'h02f0);
        wr(ADDR_BAUD_LO, 8'h00);
        chk_baud(16'h02f0);
        wr(ADDR_BAUD_HI, 8'h00);
        chk_baud(16'h0000);
        // table of writes and read-backs
        foreach (rows[i])
        begin
            wr(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16], rows[i][7:0]);
        end
        chk8("own address", 8'h4c, own_addr);
        // one pin of each drive kind per nibble, latch low except on the input-only pins
        wr(ADDR_CFG_LO, 8'he4);
        wr(ADDR_CFG_HI, 8'he4);
        wr(ADDR_PIN_LEVEL, 8'h00);
        repeat (2) tick1();
        chk8("drive enable", 8'hdd, pin_oe);
        chk8("drive value", 8'h00, pin_out & pin_oe);
        // input pin kept its latch; made push-pull it drives one
        wr(ADDR_CFG_LO, 8'he8);
        repeat (2) tick1();
        chk8("kept latch", 8'h02, pin_out & pin_oe);
        wr(ADDR_CFG_LO, 8'he4);
        wr(ADDR_PIN_LEVEL, 8'hff);
        repeat (2) tick1();
        chk8("drive enable", 8'h44, pin_oe);
        chk8("drive value", 8'h44, pin_out & pin_oe);
        chk8("weak pull", 8'h11, pin_weak);
        ext_low <= 8'h0b;
        rd(ADDR_PIN_LEVEL, 8'hf4);
        ext_low <= 8'h00;
        // clock phases from counts 5 low and 3 high
        // first low run after idle is partial, so high is measured first
        i2c_active <= 1'b1;
        scl_run(1'b1, n);
        chk_rng("scl high", 78, 85, n);
        scl_run(1'b0, n);
        chk_rng("scl low", 132, 139, n);
        // stuck line with time-out disabled, then with reloads
        scl_hold <= 1'b1;
        repeat (300) @(posedge clk);
        chk_rng("disabled resets", 0, 0, fires);
        wr(ADDR_TIMEOUT, 8'h03);
        // reload as the enable lands, the counter ran while disabled
        i2c_step <= 1'b1;
        @(posedge clk);
        i2c_step <= 1'b0;
        fires = 0;
        repeat (15)
        begin
            repeat (20) @(posedge clk);
            i2c_step <= 1'b1;
            @(posedge clk);
            i2c_step <= 1'b0;
        end
        chk_rng("early resets", 0, 0, fires);
        n = 0;
        while (fires == 0 && n < 300)
        begin
            tick1();
            n++;
        end
        chk_rng("time-out delay", 35, 80, n);
        scl_hold <= 1'b0;
        i2c_active <= 1'b0;
        rd(ADDR_RESULT, 8'hf8);
        for (int c = 0; c < 3; c++)
        begin
            @(posedge clk);
            result_code <= c[3:0];
            result_valid <= 1'b1;
            @(posedge clk);
            result_valid <= 1'b0;
            rd(ADDR_RESULT, {4'hf, c[3:0]});
        end
        // second reset in mid-run
        resetn <= 1'b0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        rd(ADDR_SCL_LOW, 8'h13);
        rd(ADDR_BAUD_LO, 8'hf0);
        summarize();
    end
endmodule
